// ==== design/dma_desc_engine.sv ====
// five-channel dma engine: fetches, latches and decodes eight-byte descriptors
// assumes a byte-wide memory port shared with the cpu and an apb master
//
// How it works
// - source address is byte0 high, byte1 low
// - destination is byte2 high, byte3 low
// - fixed codes move exactly the transfer count
// - variable codes plus one or exact, capped
// - codes plus two, plus three; three reserved
// - word width takes length bits 12:0
// - byte width uses eight or seven bits
// - thirteen-bit count, words or bytes, as maximum
// - width bit selects 8 or 16 bits
// - pattern: single, block, repeated single, repeated block
// - trigger zero means manual request only
// - trigger one follows previous channel completion
// - higher trigger codes select peripheral events
// - source steps zero, one, two, minus one
// - destination steps with the same encoding
// - interrupt enable gates completion interrupt
// - low priority yields the bus to cpu
// - guaranteed priority wins every second try
// - high priority beats cpu; code 11 reserved
// - channel 0 own pointer; 1-4 packed region
// - arming a channel fetches its descriptor
// - completion flag set regardless of enable
// - non-repeating patterns disarm on completion
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module dma_desc_engine
    import dma_desc_pkg::*;
(
    input  wire logic        clk_in,          // 200 mhz system clock
    input  wire logic        reset_in,        // synchronous, active high
    input  wire logic        psel_in,         // apb select
    input  wire logic        penable_in,      // apb enable
    input  wire logic        pwrite_in,       // apb direction
    input  wire logic [7:0]  paddr_in,        // apb byte address
    input  wire logic [31:0] pwdata_in,       // apb write data
    output logic      [31:0] prdata_out,      // apb read data
    output logic             pready_out,      // apb ready
    output logic             pslverr_out,     // apb error, unmapped address
    input  wire logic        cpu_bus_req_in,  // cpu wants the memory bus
    input  wire logic [31:0] trigger_in,      // peripheral event pulses
    output logic             mem_req_out,     // memory access request
    output logic             mem_write_out,   // memory access is a write
    output logic      [15:0] mem_addr_out,    // memory byte address
    output logic      [7:0]  mem_wdata_out,   // memory write byte
    input  wire logic [7:0]  mem_rdata_in,    // memory read byte, valid with ack
    input  wire logic        mem_ack_in,      // memory access done
    output logic             dma_irq_out      // completion interrupt
);
    engine_state_type state_q, state_d;
    logic [2:0]  ch_q, ch_d, idx_q, idx_d, pick;
    logic [1:0]  sub_q, sub_d;
    logic [12:0] units_q, units_d, total_q, total_d;
    logic [15:0] src_q, src_d, dst_q, dst_d, data_q, data_d;
    logic [15:0] ptr0_q, ptr1_q;
    logic [4:0]  arm_q, req_q, flag_q, irqen_q, chain_q;
    logic [7:0]  desc_q [DESC_BYTES];
    logic        mreq_d, mwe_d, desc_we, pick_valid, lost_q;
    logic [15:0] maddr_d;
    logic [7:0]  mwd_d;
    logic        mem_req_q, mem_write_q, pready_q, pslverr_q, irq_q;
    logic [15:0] mem_addr_q;
    logic [7:0]  mem_wdata_q;
    logic [31:0] prdata_q;

    // descriptor decode
    wire [15:0] src_addr_w = {desc_q[B_SRC_HI], desc_q[B_SRC_LO]};
    wire [15:0] dst_addr_w = {desc_q[B_DST_HI], desc_q[B_DST_LO]};
    wire [2:0]  variable_length_select_w     = desc_q[B_VARIABLE_LENGTH_SELECT_LIM][VARIABLE_LENGTH_SELECT_MSB:VARIABLE_LENGTH_SELECT_LSB];
    wire [12:0] limit_w    = {desc_q[B_VARIABLE_LENGTH_SELECT_LIM][LIM_HI_MSB:0], desc_q[B_LIM_LO]};
    wire        word_w     = desc_q[B_MODE][WIDTH_BIT];
    wire [1:0]  pattern_w  = desc_q[B_MODE][PAT_MSB:PAT_LSB];
    wire [4:0]  trigger_select_w     = desc_q[B_MODE][TRIGGER_SELECT_MSB:0];
    wire [1:0]  sstep_w    = desc_q[B_STEP][SSTEP_MSB:SSTEP_LSB];
    wire [1:0]  dstep_w    = desc_q[B_STEP][DSTEP_MSB:DSTEP_LSB];
    wire        irq_en_w   = desc_q[B_STEP][IRQ_BIT];
    wire        m7_w       = desc_q[B_STEP][M7_BIT];
    wire [1:0]  prio_w     = desc_q[B_STEP][PRIO_MSB:0];

    wire is_var = (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS1) || (variable_length_select_w == VARIABLE_LENGTH_SELECT_EXACT) ||
                  (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS2) || (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS3);

    // length from first unit; low byte arrives first, so it sits in data_q
    wire [12:0] len_word = {mem_rdata_in[4:0], data_q[7:0]};
    wire [12:0] len_byte = m7_w ? {6'h00, mem_rdata_in[6:0]} : {5'h00, mem_rdata_in};
    wire [12:0] len_val  = word_w ? len_word : len_byte;
    // plus one or exact; plus two or three
    wire [13:0] len_adj  = (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS1) ? 14'h0001 :
                           (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS2) ? 14'h0002 :
                           (variable_length_select_w == VARIABLE_LENGTH_SELECT_PLUS3) ? 14'h0003 : 14'h0000;
    wire [13:0] len_sum  = {1'b0, len_val} + len_adj;
    // transfer count caps the variable length
    wire [12:0] len_cap  = (len_sum > {1'b0, limit_w}) ? limit_w : len_sum[12:0];

    // channel 0 own pointer, channels 1-4 eight bytes apart
    wire [2:0]  ch_m1      = ch_q - 3'h1;
    wire [15:0] fetch_base = (ch_q == 3'h0) ? ptr0_q : ptr1_q + {10'h000, ch_m1, 3'h0};
    wire [15:0] fetch_addr = fetch_base + {13'h0000, idx_q};

    wire [4:0]  ch_hot     = 5'(5'h01 << ch_q);
    wire        armed      = |(arm_q & ch_hot);

    // manual only; previous channel; peripheral list
    wire fire = |(req_q & ch_hot) ||
                ((trigger_select_w == TRIGGER_SELECT_PREV) && |(chain_q & ch_hot)) ||
                ((trigger_select_w > TRIGGER_SELECT_PREV) && trigger_in[trigger_select_w]);
    wire [4:0] grant_hot = (state_q == ST_WAIT && armed && fire) ? ch_hot : 5'h00;

    wire       done      = (state_q == ST_DONE);
    wire [4:0] done_hot  = done ? ch_hot : 5'h00;
    wire [4:0] disarm    = pattern_w[PAT_REPEAT_BIT] ? 5'h00 : done_hot;

    // the fetch has no priority code yet, so it alternates like the guaranteed level
    wire [1:0] prio_eff  = (state_q == ST_FETCH) ? PRIO_GUAR : prio_w;
    wire       want      = (state_q == ST_FETCH || state_q == ST_XFER) && !mem_req_q && armed;
    // low yields; every second try; high wins, 11 as low
    wire       bus_ok    = (prio_eff == PRIO_HIGH) || !cpu_bus_req_in ||
                           ((prio_eff == PRIO_GUAR) && lost_q);

    wire       read_last  = word_w ? sub_q[0] : 1'b1;
    wire       last_unit  = ({1'b0, units_q} + 14'h0001) >= {1'b0, total_q};
    wire [15:0] unit_off  = {15'h0000, sub_q[0]};

    // step of one unit, two units or back one
    function automatic logic [15:0] step_delta(input logic [1:0] code, input logic wide);
        logic [15:0] u;
        u = wide ? 16'h0002 : 16'h0001;
        case (code)
            STEP_ONE:  step_delta = u;
            STEP_TWO:  step_delta = {u[14:0], 1'b0};
            STEP_BACK: step_delta = 16'h0000 - u;
            default:   step_delta = 16'h0000;
        endcase
    endfunction

    // round robin from the channel after the last one served
    always_comb begin
        int c;
        c = 0;
        pick_valid = 1'b0;
        pick = ch_q;
        for (int i = NUM_CH; i >= 1; i--) begin
            c = (int'(ch_q) + i) % NUM_CH;
            if (arm_q[c]) begin
                pick_valid = 1'b1;
                pick = 3'(c);
            end
        end
    end

    always_comb begin
        state_d = state_q;
        ch_d    = ch_q;
        idx_d   = idx_q;
        sub_d   = sub_q;
        units_d = units_q;
        total_d = total_q;
        src_d   = src_q;
        dst_d   = dst_q;
        data_d  = data_q;
        mreq_d  = mem_req_q;
        mwe_d   = mem_write_q;
        maddr_d = mem_addr_q;
        mwd_d   = mem_wdata_q;
        desc_we = 1'b0;
        unique case (state_q)
            // an armed channel starts with its descriptor fetch
            ST_IDLE: if (pick_valid) begin
                ch_d    = pick;
                idx_d   = 3'h0;
                state_d = ST_FETCH;
            end
            ST_FETCH: if (mem_req_q) begin
                if (mem_ack_in) begin
                    mreq_d  = 1'b0;
                    desc_we = 1'b1;
                    idx_d   = idx_q + 3'h1;
                    // transfers wait until byte 7 is in
                    if (idx_q == 3'h7) begin
                        state_d = ST_WAIT;
                        src_d   = src_addr_w;
                        dst_d   = dst_addr_w;
                        units_d = 13'h0000;
                        total_d = limit_w;
                    end
                end
            end else if (!armed) begin
                state_d = ST_IDLE;
            end else if (bus_ok) begin
                mreq_d  = 1'b1;
                mwe_d   = 1'b0;
                maddr_d = fetch_addr;
            end
            ST_WAIT: if (!armed) begin
                state_d = ST_IDLE;
            end else if (fire) begin
                sub_d   = 2'h0;
                // a zero fixed count completes at once
                state_d = (!is_var && limit_w == 13'h0000) ? ST_DONE : ST_XFER;
            end
            ST_XFER: if (mem_req_q) begin
                if (mem_ack_in) begin
                    mreq_d = 1'b0;
                    if (!sub_q[1]) begin
                        if (sub_q[0]) data_d[15:8] = mem_rdata_in;
                        else data_d[7:0] = mem_rdata_in;
                        sub_d = read_last ? 2'h2 : 2'h1;
                        // length taken from the first unit
                        if (read_last && is_var && units_q == 13'h0000) total_d = len_cap;
                    end else if (!read_last) begin
                        sub_d = 2'h3;
                    end else begin
                        sub_d   = 2'h0;
                        units_d = units_q + 13'h0001;
                        src_d   = src_q + step_delta(sstep_w, word_w);
                        dst_d   = dst_q + step_delta(dstep_w, word_w);
                        // single waits for a trigger per unit, block runs on
                        if (last_unit) state_d = ST_DONE;
                        else if (!pattern_w[PAT_BLOCK_BIT]) state_d = ST_WAIT;
                    end
                end
            end else if (!armed) begin
                state_d = ST_IDLE;
            end else if (bus_ok) begin
                // word width moves two bytes per unit
                mreq_d  = 1'b1;
                mwe_d   = sub_q[1];
                maddr_d = sub_q[1] ? dst_q + unit_off : src_q + unit_off;
                mwd_d   = sub_q[0] ? data_q[15:8] : data_q[7:0];
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= ST_IDLE;
            ch_q    <= 3'h0;
            idx_q   <= 3'h0;
            sub_q   <= 2'h0;
            units_q <= 13'h0000;
            total_q <= 13'h0000;
            src_q   <= 16'h0000;
            dst_q   <= 16'h0000;
            data_q  <= 16'h0000;
        end else begin
            state_q <= state_d;
            ch_q    <= ch_d;
            idx_q   <= idx_d;
            sub_q   <= sub_d;
            units_q <= units_d;
            total_q <= total_d;
            src_q   <= src_d;
            dst_q   <= dst_d;
            data_q  <= data_d;
        end
    end

    // a request is never withdrawn before its ack, even on abort
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mem_req_q   <= 1'b0;
            mem_write_q <= 1'b0;
            mem_addr_q  <= 16'h0000;
            mem_wdata_q <= 8'h00;
        end else begin
            mem_req_q   <= mreq_d;
            mem_write_q <= mwe_d;
            mem_addr_q  <= maddr_d;
            mem_wdata_q <= mwd_d;
        end
    end

    // one lost attempt guarantees the next
    always_ff @(posedge clk_in) begin
        if (reset_in) lost_q <= 1'b0;
        else if (want) lost_q <= !bus_ok;
    end

    for (genvar g = 0; g < DESC_BYTES; g++) begin : g_desc
        always_ff @(posedge clk_in) begin
            if (reset_in) desc_q[g] <= 8'h00;
            else if (desc_we && idx_q == 3'(g)) desc_q[g] <= mem_rdata_in;
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle
    wire setup  = psel_in && !penable_in;
    wire hit_p0 = (paddr_in == ADDR_CH0_PTR);
    wire hit_p1 = (paddr_in == ADDR_CH14_PTR);
    wire hit_ar = (paddr_in == ADDR_ARM);
    wire hit_rq = (paddr_in == ADDR_REQ);
    wire hit_fl = (paddr_in == ADDR_FLAGS);
    wire hit_st = (paddr_in == ADDR_STATUS);
    wire mapped = hit_p0 || hit_p1 || hit_ar || hit_rq || hit_fl || hit_st;
    wire wr     = psel_in && penable_in && pwrite_in && pready_q && mapped;
    wire abort  = pwdata_in[ARM_ABORT_BIT];
    wire [31:0] status_w = {3'h0, units_q, 9'h000, ch_q, 1'b0, state_q};
    wire [31:0] rd_data  = hit_p0 ? {16'h0000, ptr0_q} :
                           hit_p1 ? {16'h0000, ptr1_q} :
                           hit_ar ? {27'h0000000, arm_q} :
                           hit_rq ? {27'h0000000, req_q} :
                           hit_fl ? {27'h0000000, flag_q} :
                           hit_st ? status_w : 32'h00000000;

    // software arming wins over the hardware disarm in the same cycle
    wire [4:0] arm_d   = (wr && hit_ar) ? (abort ? arm_q & ~pwdata_in[4:0] & ~disarm
                                                 : pwdata_in[4:0])
                                        : arm_q & ~disarm;
    // manual request: write 1 sets, cleared on grant, a set wins
    wire [4:0] req_d   = (req_q & ~grant_hot) | ((wr && hit_rq) ? pwdata_in[4:0] : 5'h00);
    // completion sets the flag whatever the enable; writing 0 clears
    wire [4:0] flag_d  = ((wr && hit_fl) ? flag_q & pwdata_in[4:0] : flag_q) | done_hot;
    wire [4:0] irqen_d = (irqen_q & ~done_hot) | (irq_en_w ? done_hot : 5'h00);
    // completion of channel n arms the chain trigger of n+1
    wire [4:0] chain_d = (chain_q & ~grant_hot) | {done_hot[3:0], done_hot[4]};

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ptr0_q    <= PTR_RESET;
            ptr1_q    <= PTR_RESET;
            arm_q     <= BITS_RESET;
            req_q     <= BITS_RESET;
            flag_q    <= BITS_RESET;
            irqen_q   <= BITS_RESET;
            chain_q   <= BITS_RESET;
            prdata_q  <= 32'h00000000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            if (wr && hit_p0) ptr0_q <= pwdata_in[15:0];
            if (wr && hit_p1) ptr1_q <= pwdata_in[15:0];
            arm_q     <= arm_d;
            req_q     <= req_d;
            flag_q    <= flag_d;
            irqen_q   <= irqen_d;
            chain_q   <= chain_d;
            if (setup) prdata_q <= rd_data;
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
            // only enabled channels raise the interrupt
            irq_q     <= |(flag_q & irqen_q);
        end
    end

    assign prdata_out    = prdata_q;
    assign pready_out    = pready_q;
    assign pslverr_out   = pslverr_q;
    assign mem_req_out   = mem_req_q;
    assign mem_write_out = mem_write_q;
    assign mem_addr_out  = mem_addr_q;
    assign mem_wdata_out = mem_wdata_q;
    assign dma_irq_out   = irq_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_fetch_ch0: assert property (state_q == ST_FETCH && mem_req_out && ch_q == 3'h0
        |-> mem_addr_out == ptr0_q + {13'h0000, idx_q}) else $error("ch0 fetch address");
    a_fetch_grp: assert property (state_q == ST_FETCH && mem_req_out && ch_q != 3'h0
        |-> mem_addr_out == ptr1_q + 16'(8 * (int'(ch_q) - 1)) + {13'h0000, idx_q})
        else $error("ch1-4 fetch address");
    a_src_first: assert property (state_q == ST_XFER && mem_req_out && !mem_write_out
        && units_q == 13'h0000 && sub_q == 2'h0 |-> mem_addr_out == src_addr_w)
        else $error("first read not at source");
    a_dst_first: assert property (state_q == ST_XFER && mem_req_out && mem_write_out
        && units_q == 13'h0000 && sub_q == 2'h2 |-> mem_addr_out == dst_addr_w)
        else $error("first write not at destination");
    a_low_yield: assert property ($rose(mem_req_out) && state_q == ST_XFER
        && prio_w == PRIO_LOW |-> !$past(cpu_bus_req_in)) else $error("low priority took bus");
    a_flag_set: assert property (done |=> flag_q[$past(ch_q)])
        else $error("completion flag missing");
    a_auto_disarm: assert property (done && !pattern_w[PAT_REPEAT_BIT] && !(wr && hit_ar)
        |=> !arm_q[$past(ch_q)]) else $error("channel still armed");
    a_count_cap: assert property (state_q == ST_XFER |-> units_q < limit_w)
        else $error("units beyond count");
    a_guar_turn: assert property (state_q == ST_XFER && prio_w == PRIO_GUAR && want
        && !bus_ok ##1 want |-> bus_ok) else $error("guaranteed turn lost");

    c_block_done: cover property (state_q == ST_XFER && pattern_w[PAT_BLOCK_BIT] ##[1:200] done);
    c_var_word:   cover property (state_q == ST_XFER && is_var && word_w ##[1:200] done);
    c_abort:      cover property (state_q == ST_WAIT && !armed);
endmodule

// ==== design/dma_desc_pkg.sv ====
// constants for the five-channel dma engine with eight-byte descriptors
// assumes one 200 mhz clock, a byte-wide memory port and an apb register slave
package dma_desc_pkg;
    localparam int          NUM_CH         = 5;
    localparam int          DESC_BYTES     = 8;
    // apb byte addresses
    localparam logic [7:0]  ADDR_CH0_PTR   = 8'h00;
    localparam logic [7:0]  ADDR_CH14_PTR  = 8'h04;
    localparam logic [7:0]  ADDR_ARM       = 8'h08;
    localparam logic [7:0]  ADDR_REQ       = 8'h0c;
    localparam logic [7:0]  ADDR_FLAGS     = 8'h10;
    localparam logic [7:0]  ADDR_STATUS    = 8'h14;
    localparam int          ARM_ABORT_BIT  = 7;
    // reset values
    localparam logic [15:0] PTR_RESET      = 16'h0000;
    localparam logic [4:0]  BITS_RESET     = 5'h00;
    // descriptor byte indices
    localparam int          B_SRC_HI       = 0;
    localparam int          B_SRC_LO       = 1;
    localparam int          B_DST_HI       = 2;
    localparam int          B_DST_LO       = 3;
    localparam int          B_VARIABLE_LENGTH_SELECT_LIM     = 4;
    localparam int          B_LIM_LO       = 5;
    localparam int          B_MODE         = 6;
    localparam int          B_STEP         = 7;
    // field positions inside bytes 4, 6 and 7
    localparam int          VARIABLE_LENGTH_SELECT_MSB       = 7;
    localparam int          VARIABLE_LENGTH_SELECT_LSB       = 5;
    localparam int          LIM_HI_MSB     = 4;
    localparam int          WIDTH_BIT      = 7;
    localparam int          PAT_MSB        = 6;
    localparam int          PAT_LSB        = 5;
    localparam int          TRIGGER_SELECT_MSB       = 4;
    localparam int          SSTEP_MSB      = 7;
    localparam int          SSTEP_LSB      = 6;
    localparam int          DSTEP_MSB      = 5;
    localparam int          DSTEP_LSB      = 4;
    localparam int          IRQ_BIT        = 3;
    localparam int          M7_BIT         = 2;
    localparam int          PRIO_MSB       = 1;
    // pattern bits
    localparam int          PAT_BLOCK_BIT  = 0;
    localparam int          PAT_REPEAT_BIT = 1;
    // variable length codes
    localparam logic [2:0]  VARIABLE_LENGTH_SELECT_PLUS1     = 3'h1;
    localparam logic [2:0]  VARIABLE_LENGTH_SELECT_EXACT     = 3'h2;
    localparam logic [2:0]  VARIABLE_LENGTH_SELECT_PLUS2     = 3'h3;
    localparam logic [2:0]  VARIABLE_LENGTH_SELECT_PLUS3     = 3'h4;
    // address step codes
    localparam logic [1:0]  STEP_NONE      = 2'h0;
    localparam logic [1:0]  STEP_ONE       = 2'h1;
    localparam logic [1:0]  STEP_TWO       = 2'h2;
    localparam logic [1:0]  STEP_BACK      = 2'h3;
    // bus priority codes
    localparam logic [1:0]  PRIO_LOW       = 2'h0;
    localparam logic [1:0]  PRIO_GUAR      = 2'h1;
    localparam logic [1:0]  PRIO_HIGH      = 2'h2;
    // trigger codes
    localparam logic [4:0]  TRIGGER_SELECT_NONE      = 5'h00;
    localparam logic [4:0]  TRIGGER_SELECT_PREV      = 5'h01;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_WAIT  = 3'b010,
        ST_XFER  = 3'b011,
        ST_DONE  = 3'b100
    } engine_state_type;
endpackage

// ==== sim/mem_model.sv ====
// byte-wide memory standing behind the engine's memory port
// assumes requests are held until the one-cycle acknowledge
`timescale 1ns/1ps
module mem_model (
    input  wire logic        clk_in,    // system clock
    input  wire logic        req_in,    // access request, held until ack
    input  wire logic        write_in,  // access is a write
    input  wire logic [15:0] addr_in,   // byte address
    input  wire logic [7:0]  wdata_in,  // write byte
    output logic      [7:0]  rdata_out, // read byte, valid with ack only
    output logic             ack_out    // one-cycle completion pulse
);
    logic [7:0] m [0:255];
    logic       slow_q;
    initial begin
        rdata_out = 8'h00;
        ack_out = 1'b0;
        slow_q = 1'b0;
    end
    // odd addresses answer a cycle late; read data toggles outside ack
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        slow_q <= req_in && !ack_out && !slow_q;
        if (req_in && !ack_out && (slow_q || !addr_in[0])) begin
            ack_out <= 1'b1;
            slow_q <= 1'b0;
            if (write_in) begin
                m[addr_in[7:0]] <= wdata_in;
            end else begin
                rdata_out <= m[addr_in[7:0]];
            end
        end
    end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench: apb set-up, descriptor fetch and byte transfers
// assumes the memory model answers the engine's memory port
`timescale 1ns/1ps
module testbench;
    import dma_desc_pkg::*;
    logic        clk, rst, psel, pen, pwr, pready, pslverr, mreq, mwr, mack, irq, e, cpu;
    logic [1:0]  cc;
    logic [7:0]  paddr, mwd, mrd;
    logic [15:0] maddr;
    logic [31:0] pwd, prd, r, trigger_select;
    int          fail_count, checks;
    dma_desc_engine uut (.clk_in(clk), .reset_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(pready), .pslverr_out(pslverr), .cpu_bus_req_in(cpu),
        .trigger_in(trigger_select), .mem_req_out(mreq), .mem_write_out(mwr),
        .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_rdata_in(mrd),
        .mem_ack_in(mack), .dma_irq_out(irq));
    mem_model mem (.clk_in(clk), .req_in(mreq), .write_in(mwr), .addr_in(maddr),
        .wdata_in(mwd), .rdata_out(mrd), .ack_out(mack));
    // cpu contends three cycles in four, so the low and guaranteed levels meet a refusal; high is never refused
    always @(posedge clk) begin
        cc <= cc + 2'h1;
        cpu <= cc != 2'h3;
    end
    task automatic give_verdict;
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        checks++;
        if (got !== x) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prd;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic wait_flag(input int ch);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_FLAGS, 32'h0);
            n++;
        end while (r[ch] !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (r[2:0] !== s && n < 100);
        if (n >= 100) begin
            fail_count++;
            give_verdict();
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [63:0] d);
        for (int i = 0; i < 8; i++) begin
            mem.m[a + 8'(i)] = d[63 - 8 * i -: 8];
        end
    endtask
    task automatic cmp4(input logic [7:0] a, input logic [31:0] x);
        for (int i = 0; i < 4; i++) begin
            chk(32'(mem.m[a + 8'(i)]), 32'(x[31 - 8 * i -: 8]));
        end
    endtask
    task automatic t_regs;
        apb(1'b0, ADDR_ARM, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, ADDR_CH0_PTR, 32'h1234);
        apb(1'b0, ADDR_CH0_PTR, 32'h0);
        chk(r, 32'h1234);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, e}, 32'h1);
    endtask
    // block of three bytes, manual start, high priority, interrupt on
    task automatic t_fixed;
        put(8'h20, 64'h0040_0080_0003_205a);
        put(8'h40, 64'ha0a1_a2a3_0000_0000);
        put(8'h80, 64'h0);
        apb(1'b1, ADDR_CH0_PTR, 32'h20);
        apb(1'b1, ADDR_ARM, 32'h1);
        apb(1'b1, ADDR_REQ, 32'h1);
        wait_flag(0);
        cmp4(8'h80, 32'ha0a1_a200);
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, ADDR_ARM, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    // length byte 0x82 read as seven bits gives two, plus one unit
    task automatic t_var;
        put(8'h30, 64'h0050_0090_2008_2054);
        put(8'h50, 64'h8211_2233_0000_0000);
        put(8'h90, 64'h0);
        apb(1'b1, ADDR_CH14_PTR, 32'h30);
        apb(1'b1, ADDR_ARM, 32'h2);
        apb(1'b1, ADDR_REQ, 32'h2);
        wait_flag(1);
        cmp4(8'h90, 32'h8211_2200);
        chk({31'h0, irq}, 32'h0);
    endtask
    // two words, one peripheral trigger each, source +2 words, destination -1 word
    task automatic t_word;
        put(8'h28, 64'h0060_00a2_0002_87b1);
        put(8'h60, 64'h1122_3344_5566_7788);
        put(8'ha0, 64'h0);
        apb(1'b1, ADDR_CH0_PTR, 32'h28);
        apb(1'b1, ADDR_ARM, 32'h1);
        for (int u = 0; u < 2; u++) begin
            wait_state(3'h2);
            chk({19'h0, r[28:16]}, 32'(u));
            trigger_select <= 32'h80;
            @(posedge clk);
            trigger_select <= 32'h0;
        end
        wait_flag(0);
        cmp4(8'ha0, 32'h5566_1122);
        chk({31'h0, irq}, 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {psel, pen, pwr, paddr, pwd, cpu, cc, trigger_select} = '0;
        fail_count = 0;
        checks = 0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_fixed();
        t_var();
        t_word();
        give_verdict();
    end
endmodule
